// [vtmon_top.sv]
// Voltage and temperature monitor control, limit alarms and APB registers
`timescale 1ns/1ns

module vtmon_top
   import vtmon_pkg::*;
#(
   parameter int LVL_W = 3
) (
   input wire logic MCLK_I,
   input wire logic RST_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [31:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // Measurements from the analog front end
   input wire logic SAMPLE_VALID_I,
   input wire logic [LVL_W-1:0] CH0_LEVEL_I,
   input wire logic [LVL_W-1:0] CH1_LEVEL_I,
   input wire logic [LVL_W-1:0] TEMP_LEVEL_I,
   // Controls to the analog front end
   output logic SENSE_EN_O,
   output logic [1:0] VSEL_O,
   output logic [vtmon_pkg::GAIN_W-1:0] GAIN_CODE_O,
   output logic GAIN_APPLY_O,
   // Sticky alarm flags, also in the status register
   output logic [2*vtmon_pkg::NUM_CH-1:0] ALARM_O
);
   import vtmon_pkg::*;

   // ----------------------------------------------------------------
   // Register map (word index; byte address is four times it)
   // ----------------------------------------------------------------
   // Index 0x15: gain code in 6:0, bit 7 spare but kept
   // Index 0x16: spare byte, read and write
   // Index 0x17: enable field 3:2, pin select 1:0
   // Index 0x18: gain apply in bit 7
   // Index 0x19 to 0x1b: upper limit 6:4, lower limit 2:0
   // Index 0x1d: alarm enables, one per status bit
   // Index 0x30: status, bit 2c under, 2c+1 over; write one clears
   // Index 0x31, 0x32: channel zero peak and floor, read only
   // Index 0x33, 0x34: channel one peak and floor, read only
   // Channel c is 0 and 1 for the pins, 2 for temperature
   // Any other index, or a misaligned address, answers with an error

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire logic [7:0] reg_idx;
   wire logic addr_aligned;
   wire logic setup_ph;
   wire logic access_ph;
   wire logic wr_en;
   wire logic [7:0] wbyte;

   // Word index from byte address; upper address bits must be zero
   assign reg_idx = PADDR_I[9:2];
   assign addr_aligned = (PADDR_I[1:0] == 2'h0) && (PADDR_I[31:10] == 22'h0);
   assign setup_ph = PSEL_I && !PENABLE_I;
   assign access_ph = PSEL_I && PENABLE_I;
   assign wbyte = PWDATA_I[7:0];

   // Hit lines for the configuration slots
   wire logic [NUM_CFG-1:0] cfg_hit;
   genvar s;
   generate
      for (s = 0; s < NUM_CFG; s++) begin : g_hit
         assign cfg_hit[s] = addr_aligned && (reg_idx == CFG_IDX[s]);
      end
   endgenerate

   wire logic status_hit;
   wire logic ch0_peak_hit;
   wire logic ch0_floor_hit;
   wire logic ch1_peak_hit;
   wire logic ch1_floor_hit;
   wire logic any_hit;

   // Status and read-only locations
   assign status_hit = addr_aligned && (reg_idx == IDX_STATUS);
   assign ch0_peak_hit = addr_aligned && (reg_idx == IDX_CH0_PEAK);
   assign ch0_floor_hit = addr_aligned && (reg_idx == IDX_CH0_FLOOR);
   assign ch1_peak_hit = addr_aligned && (reg_idx == IDX_CH1_PEAK);
   assign ch1_floor_hit = addr_aligned && (reg_idx == IDX_CH1_FLOOR);
   assign any_hit = (|cfg_hit) || status_hit || ch0_peak_hit || ch0_floor_hit
      || ch1_peak_hit || ch1_floor_hit;

   // Writes land on the single access edge; no wait states
   assign wr_en = access_ph && PWRITE_I;

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // Whole bytes are kept, reserved bits included, since they read back
   // Read-only and unmapped indices match no slot, so such writes are dropped
   vtmon_byte_t cfg_q [NUM_CFG];

   generate
      for (s = 0; s < NUM_CFG; s++) begin : g_cfg
         always_ff @(posedge MCLK_I) begin
            if (RST_I) begin
               cfg_q[s] <= CFG_RST[s];
            end else if (wr_en && cfg_hit[s]) begin
               cfg_q[s] <= wbyte;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Field extraction
   // ----------------------------------------------------------------
   wire logic [GAIN_W-1:0] gain_code;
   wire logic [1:0] mon_en_field;
   wire logic [1:0] vsel_field;
   wire logic gain_apply;
   wire logic mon_on;
   wire logic [2*NUM_CH-1:0] alarm_en;

   // Gain 128/code; a code of zero is meaningless and left to software
   assign gain_code = cfg_q[SLOT_GAIN][GAIN_LSB +: GAIN_W];
   assign mon_en_field = cfg_q[SLOT_CTRL_A][MON_EN_LSB +: 2];
   assign vsel_field = cfg_q[SLOT_CTRL_A][VSEL_LSB +: 2];
   assign gain_apply = cfg_q[SLOT_CTRL_B][GAIN_APPLY_BIT];
   // Only 11 counts as on; 01 and 10 are treated as off
   assign mon_on = (mon_en_field == MON_ON);
   assign alarm_en = cfg_q[SLOT_ALARM_EN][2*NUM_CH-1:0];

   // Front end controls follow the register fields directly
   // Gain apply only steers the front end; limits are not rescaled
   assign VSEL_O = vsel_field;
   assign GAIN_CODE_O = gain_code;
   assign GAIN_APPLY_O = gain_apply;

   // ----------------------------------------------------------------
   // Sense enable output
   // ----------------------------------------------------------------
   logic sense_en_q;
   wire logic sense_en_d;
   wire logic ctrl_a_wr;

   // Loaded on the same edge as the control byte, so it always equals mon_on,
   // but the pin to the front end is a flop output and cannot glitch
   assign ctrl_a_wr = wr_en && cfg_hit[SLOT_CTRL_A];
   assign sense_en_d = ctrl_a_wr ? (wbyte[MON_EN_LSB +: 2] == MON_ON) : sense_en_q;

   // Enabled out of reset, as the control byte is
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         sense_en_q <= (RST_CTRL_A[MON_EN_LSB +: 2] == MON_ON);
      end else begin
         sense_en_q <= sense_en_d;
      end
   end

   assign SENSE_EN_O = sense_en_q;

   // ----------------------------------------------------------------
   // Limit comparison per channel
   // ----------------------------------------------------------------
   wire logic [LVL_W-1:0] level [NUM_CH];
   wire logic [NUM_CH-1:0] ch_active;
   wire logic [2*NUM_CH-1:0] alarm_evt;

   assign level[0] = CH0_LEVEL_I;
   assign level[1] = CH1_LEVEL_I;
   assign level[CH_TEMP] = TEMP_LEVEL_I;

   // Voltage channels need their pin selected; temperature needs only enable
   assign ch_active[0] = mon_on && vsel_field[0];
   assign ch_active[1] = mon_on && vsel_field[1];
   assign ch_active[CH_TEMP] = mon_on;

   genvar c;
   generate
      for (c = 0; c < NUM_CH; c++) begin : g_cmp
         wire logic [LIMIT_W-1:0] upper;
         wire logic [LIMIT_W-1:0] lower;
         wire logic [LVL_W-1:0] upper_ext;
         wire logic [LVL_W-1:0] lower_ext;
         wire logic sample_ok;

         assign upper = cfg_q[SLOT_CH0_LIM + c][UPPER_LSB +: LIMIT_W];
         assign lower = cfg_q[SLOT_CH0_LIM + c][LOWER_LSB +: LIMIT_W];
         // Limits share the scale of the level code
         assign upper_ext = LVL_W'(upper);
         assign lower_ext = LVL_W'(lower);
         assign sample_ok = SAMPLE_VALID_I && ch_active[c];
         // Strict comparisons: a level equal to a limit raises nothing
         // Enables gate at set time; dropping one later leaves the flag
         assign alarm_evt[2*c+1] = sample_ok && (level[c] > upper_ext)
            && alarm_en[2*c+1];
         assign alarm_evt[2*c] = sample_ok && (level[c] < lower_ext)
            && alarm_en[2*c];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Sticky alarm status
   // ----------------------------------------------------------------
   logic [2*NUM_CH-1:0] alarm_q;
   logic [2*NUM_CH-1:0] alarm_d;
   wire logic [2*NUM_CH-1:0] alarm_clr;

   // Write one to clear; a new event in the same cycle keeps the bit set
   assign alarm_clr = (wr_en && status_hit) ? wbyte[2*NUM_CH-1:0] : '0;

   always_comb begin
      alarm_d = (alarm_q & ~alarm_clr) | alarm_evt;
   end

   // Status flags hold until cleared
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         alarm_q <= '0;
      end else begin
         alarm_q <= alarm_d;
      end
   end

   // Pins show exactly the flags that the status register reads
   assign ALARM_O = alarm_q;

   // ----------------------------------------------------------------
   // Peak and floor tracking for the voltage channels
   // ----------------------------------------------------------------
   logic [LVL_W-1:0] peak_q [2];
   logic [LVL_W-1:0] floor_q [2];
   logic [1:0] seen_q;

   generate
      for (c = 0; c < 2; c++) begin : g_track
         wire logic take;
         wire logic new_peak;
         wire logic new_floor;

         // Tracking runs whenever the channel is measured, alarms or not
         assign take = SAMPLE_VALID_I && ch_active[c];
         // First sample loads both, so the reset values never stick
         assign new_peak = take && (!seen_q[c] || (level[c] > peak_q[c]));
         assign new_floor = take && (!seen_q[c] || (level[c] < floor_q[c]));

         // Largest and smallest measurement since reset
         // Software cannot clear them; only reset starts a new window
         always_ff @(posedge MCLK_I) begin
            if (RST_I) begin
               peak_q[c] <= '0;
               floor_q[c] <= '1;
               seen_q[c] <= 1'b0;
            end else begin
               if (new_peak) begin
                  peak_q[c] <= level[c];
               end
               if (new_floor) begin
                  floor_q[c] <= level[c];
               end
               if (take) begin
                  seen_q[c] <= 1'b1;
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------
   wire logic [7:0] cfg_or [NUM_CFG+1];
   wire logic [7:0] cfg_rd;
   wire logic [7:0] status_byte;
   wire logic [7:0] ch0_peak_byte;
   wire logic [7:0] ch0_floor_byte;
   wire logic [7:0] ch1_peak_byte;
   wire logic [7:0] ch1_floor_byte;
   wire logic ro_hit;
   wire logic [7:0] ro_byte;
   wire logic [7:0] rd_byte;
   logic [31:0] prdata_q;

   // One-hot hit lines make an OR of masked bytes a safe mux
   assign cfg_or[0] = 8'h00;
   generate
      for (s = 0; s < NUM_CFG; s++) begin : g_rd
         assign cfg_or[s+1] = cfg_or[s] | (cfg_hit[s] ? cfg_q[s] : 8'h00);
      end
   endgenerate
   assign cfg_rd = cfg_or[NUM_CFG];

   // Narrow status and level codes read back zero-extended
   assign status_byte = 8'(alarm_q);
   assign ch0_peak_byte = 8'(peak_q[0]);
   assign ch0_floor_byte = 8'(floor_q[0]);
   assign ch1_peak_byte = 8'(peak_q[1]);
   assign ch1_floor_byte = 8'(floor_q[1]);

   // Read-only locations never share an index with a configuration slot
   assign ro_hit = status_hit || ch0_peak_hit || ch0_floor_hit || ch1_peak_hit
      || ch1_floor_hit;
   assign ro_byte = status_hit ? status_byte
      : ch0_peak_hit ? ch0_peak_byte
      : ch0_floor_hit ? ch0_floor_byte
      : ch1_peak_hit ? ch1_peak_byte
      : ch1_floor_byte;
   assign rd_byte = ro_hit ? ro_byte : cfg_rd;

   // Captured in setup so the data stands from flops through the access cycle
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata_q <= (!PWRITE_I && any_hit) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Bus answer
   // ----------------------------------------------------------------
   wire logic bus_err;

   // Unmapped or misaligned: write dropped, read zero, error in access
   assign bus_err = access_ph && !any_hit;

   // Zero wait states; read data is already loaded during setup
   assign PRDATA_O = prdata_q;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = bus_err;

endmodule

// [vtmon_pkg.sv]
// Package of register map, field layout and reset values for the monitor
package vtmon_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_GAIN = 8'h15;
   localparam logic [7:0] IDX_RSVD16 = 8'h16;
   localparam logic [7:0] IDX_CTRL_A = 8'h17;
   localparam logic [7:0] IDX_CTRL_B = 8'h18;
   localparam logic [7:0] IDX_CH0_LIM = 8'h19;
   localparam logic [7:0] IDX_CH1_LIM = 8'h1a;
   localparam logic [7:0] IDX_TEMP_LIM = 8'h1b;
   localparam logic [7:0] IDX_ALARM_EN = 8'h1d;
   localparam logic [7:0] IDX_STATUS = 8'h30;
   localparam logic [7:0] IDX_CH0_PEAK = 8'h31;
   localparam logic [7:0] IDX_CH0_FLOOR = 8'h32;
   localparam logic [7:0] IDX_CH1_PEAK = 8'h33;
   localparam logic [7:0] IDX_CH1_FLOOR = 8'h34;

   // ----------------------------------------------------------------
   // Reset values of the whole bytes
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_GAIN = 8'h20;
   localparam logic [7:0] RST_RSVD16 = 8'h18;
   localparam logic [7:0] RST_CTRL_A = 8'h3c;
   localparam logic [7:0] RST_CTRL_B = 8'h80;
   localparam logic [7:0] RST_LIMITS = 8'h62;
   localparam logic [7:0] RST_ALARM_EN = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int GAIN_LSB = 0;
   localparam int GAIN_W = 7;
   localparam int MON_EN_LSB = 2;
   localparam int VSEL_LSB = 0;
   localparam int GAIN_APPLY_BIT = 7;
   localparam int UPPER_LSB = 4;
   localparam int LOWER_LSB = 0;
   localparam int LIMIT_W = 3;
   localparam logic [1:0] MON_ON = 2'h3;

   // Status and alarm enable bits: channel c uses bits 2c (under), 2c+1 (over)
   localparam int NUM_CH = 3;
   localparam int CH_TEMP = 2;

   // Configuration register slots held in the register array
   localparam int NUM_CFG = 8;
   typedef logic [7:0] vtmon_byte_t;
   localparam vtmon_byte_t CFG_IDX [NUM_CFG] = '{IDX_GAIN, IDX_RSVD16,
      IDX_CTRL_A, IDX_CTRL_B, IDX_CH0_LIM, IDX_CH1_LIM, IDX_TEMP_LIM, IDX_ALARM_EN};
   localparam vtmon_byte_t CFG_RST [NUM_CFG] = '{RST_GAIN, RST_RSVD16,
      RST_CTRL_A, RST_CTRL_B, RST_LIMITS, RST_LIMITS, RST_LIMITS, RST_ALARM_EN};
   localparam int SLOT_GAIN = 0;
   localparam int SLOT_CTRL_A = 2;
   localparam int SLOT_CTRL_B = 3;
   localparam int SLOT_CH0_LIM = 4;
   localparam int SLOT_ALARM_EN = 7;

endpackage

// [vtmon_props.sv]
// Port assertions for the monitor, bound into the top module
`timescale 1ns/1ns
module vtmon_props
   import vtmon_pkg::*;
#(
   parameter int LVL_W = 3
) (
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [31:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic PSLVERR_O,
   input wire logic SAMPLE_VALID_I,
   input wire logic [LVL_W-1:0] CH0_LEVEL_I,
   input wire logic SENSE_EN_O,
   input wire logic [1:0] VSEL_O,
   input wire logic [vtmon_pkg::GAIN_W-1:0] GAIN_CODE_O,
   input wire logic GAIN_APPLY_O,
   input wire logic [2*vtmon_pkg::NUM_CH-1:0] ALARM_O
);
   // ------
   // Checks
   // ------
   // A status write may drop flags, so hold checks leave it out
   wire st_wr = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I[9:2] == IDX_STATUS);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);
   chk_off_quiet: assert property (!SENSE_EN_O && !st_wr |=> $stable(ALARM_O))
      else $error("alarm changed while monitor off");
   chk_alarm_hold: assert property (!SAMPLE_VALID_I && !st_wr |=> $stable(ALARM_O))
      else $error("alarm changed with no sample or clear");
   chk_ch0_unsel: assert property (!VSEL_O[0] && !st_wr |=> $stable(ALARM_O[1:0]))
      else $error("channel zero alarm while unselected");
   chk_ch1_unsel: assert property (!VSEL_O[1] && !st_wr |=> $stable(ALARM_O[3:2]))
      else $error("channel one alarm while unselected");
   chk_ch0_strict: assert property (CH0_LEVEL_I == '1 && !st_wr |=> $stable(ALARM_O[0]))
      else $error("under alarm from top level");
   chk_clear_w1c: assert property (st_wr && !SAMPLE_VALID_I
      |=> (ALARM_O & $past(PWDATA_I[5:0])) == 6'h00)
      else $error("status bit not cleared");
   chk_unmapped_err: assert property (PSEL_I && PENABLE_I && PADDR_I == 32'h70 |-> PSLVERR_O)
      else $error("no error on unmapped access");
   chk_reset_state: assert property (disable iff (1'b0) RST_I |=> SENSE_EN_O
      && GAIN_APPLY_O && VSEL_O == 2'h0 && GAIN_CODE_O == 7'h20 && ALARM_O == 6'h00)
      else $error("outputs not at reset values");
   cov_over: cover property (SAMPLE_VALID_I ##1 $rose(ALARM_O[1]));
   cov_clear: cover property (st_wr && |ALARM_O);
   cov_err: cover property (PSLVERR_O);
endmodule

bind vtmon_top vtmon_props #(.LVL_W(LVL_W)) i_vtmon_props (.*);

// [vtmon_afe_model.sv]
// Behavioural model of the analog front end feeding level samples
`timescale 1ns/1ns
module vtmon_afe_model #(
   parameter int LVL_W = 3
) (
   input wire logic clk_i,
   input wire logic fire_i,
   input wire logic [3*LVL_W-1:0] lvl_i,
   output logic valid_o,
   output logic [3*LVL_W-1:0] lvl_o
);
   initial begin
      valid_o = 1'b0;
      lvl_o = '0;
   end
   // One-cycle strobe; codes are inverted between samples so stale
   // levels never pass for a fresh measurement
   always @(posedge clk_i) begin
      valid_o <= fire_i;
      lvl_o <= fire_i ? lvl_i : ~lvl_o;
   end
endmodule

// [tb_voltage_temp_monitor_limits.sv]
// Self-checking bench for the voltage and temperature monitor
`timescale 1ns/1ns
module tb_voltage_temp_monitor_limits;
   import vtmon_pkg::*;
   logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fire = 0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rdv;
   logic pready, pslverr, valid, sense_en, gapply;
   logic [8:0] lvl = '0, lv;
   logic [1:0] vsel;
   logic [6:0] gain;
   logic [5:0] alarm, exp_al, m;
   logic [7:0] ctrl, en, wd;
   logic [7:0] lim [3];
   logic [2:0] pk [2], fl [2];
   logic seen [2];
   int n_fail = 0, samples_checked = 0;

   initial forever #2 clk = ~clk;
   vtmon_afe_model #(.LVL_W(3)) i_vtmon_afe_model (.clk_i(clk), .fire_i(fire), .lvl_i(lvl),
      .valid_o(valid), .lvl_o(lv));
   vtmon_top #(.LVL_W(3)) i_vtmon_top (.MCLK_I(clk), .RST_I(rst), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .SAMPLE_VALID_I(valid), .CH0_LEVEL_I(lv[2:0]),
      .CH1_LEVEL_I(lv[5:3]), .TEMP_LEVEL_I(lv[8:6]), .SENSE_EN_O(sense_en), .VSEL_O(vsel),
      .GAIN_CODE_O(gain), .GAIN_APPLY_O(gapply), .ALARM_O(alarm));

   // ------
   // Tasks
   // ------
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
      samples_checked++;
      if (got !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, e, got);
      end
   endtask

   // Request held until pready is seen high; bounded wait
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic ee);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= {22'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         n_fail++;
         end_of_test();
      end
      rdv = prdata;
      chk($sformatf("error at %h", idx), {31'h0, ee}, {31'h0, pslverr});
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic ee);
      apb(1'b0, idx, 8'h00, ee);
      chk($sformatf("register %h", idx), {24'h0, e}, rdv);
   endtask

   task automatic do_reset;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int c = 0; c < 2; c++) begin
         pk[c] = 3'h0;
         fl[c] = 3'h7;
         seen[c] = 1'b0;
      end
   endtask

   function automatic logic [1:0] hit(input logic [2:0] l, input logic [7:0] lb,
      input logic [1:0] e, input logic act);
      return {act & e[1] & (l > lb[6:4]), act & e[0] & (l < lb[2:0])};
   endfunction

   // Random sample stream, back to back at times; mirrors alarms and extremes
   task automatic run(input int n);
      logic [8:0] v;
      logic [2:0] x;
      logic f, on;
      on = (ctrl[3:2] == MON_ON);
      repeat (n) begin
         @(posedge clk);
         f = 1'($urandom_range(0, 1));
         v = 9'($urandom);
         fire <= f;
         lvl <= v;
         if (f) begin
            exp_al |= {hit(v[8:6], lim[2], en[5:4], on), hit(v[5:3], lim[1], en[3:2],
               on & ctrl[1]), hit(v[2:0], lim[0], en[1:0], on & ctrl[0])};
            for (int c = 0; c < 2; c++) begin
               x = v[3*c +: 3];
               if (on && ctrl[c] && (!seen[c] || x > pk[c])) pk[c] = x;
               if (on && ctrl[c] && (!seen[c] || x < fl[c])) fl[c] = x;
               seen[c] |= on & ctrl[c];
            end
         end
      end
      @(posedge clk);
      fire <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   // ------
   // Main sequence
   // ------
   initial begin
      void'($urandom(32'hc0bb6396));
      do_reset();
      for (int i = 0; i < NUM_CFG; i++) rd(CFG_IDX[i], CFG_RST[i], 1'b0);
      rd(IDX_STATUS, 8'h00, 1'b0);
      rd(IDX_CH1_FLOOR, 8'h07, 1'b0);
      chk("gain port", 32'h20, {25'h0, gain});
      chk("apply port", 32'h1, {31'h0, gapply});
      apb(1'b1, 8'h1c, 8'hff, 1'b1);
      rd(8'h1c, 8'h00, 1'b1);
      apb(1'b1, IDX_CH0_PEAK, 8'h05, 1'b0);
      rd(IDX_CH0_PEAK, 8'h00, 1'b0);
      for (int i = 0; i < NUM_CFG; i++) begin
         wd = 8'($urandom);
         apb(1'b1, CFG_IDX[i], wd, 1'b0);
         rd(CFG_IDX[i], wd, 1'b0);
         if (i == SLOT_GAIN) chk("gain port", {25'h0, wd[6:0]}, {25'h0, gain});
         if (i == SLOT_CTRL_B) chk("apply port", {31'h0, wd[7]}, {31'h0, gapply});
      end
      $display("register test done");
      // First round all on; later rounds pick enable and pin modes at random
      for (int r = 0; r < 14; r++) begin
         ctrl = (r == 0) ? 8'h3f : {4'h3, 4'($urandom)};
         en = (r == 0) ? 8'h3f : 8'($urandom) & 8'h3f;
         apb(1'b1, IDX_CTRL_A, ctrl, 1'b0);
         apb(1'b1, IDX_ALARM_EN, en, 1'b0);
         for (int i = 0; i < 3; i++) begin
            lim[i] = 8'($urandom) & 8'h77;
            apb(1'b1, IDX_CH0_LIM + 8'(i), lim[i], 1'b0);
         end
         chk("sense port", {31'h0, ctrl[3:2] == 2'h3}, {31'h0, sense_en});
         chk("select port", {30'h0, ctrl[1:0]}, {30'h0, vsel});
         apb(1'b1, IDX_STATUS, 8'h3f, 1'b0);
         exp_al = '0;
         run(30);
         rd(IDX_STATUS, {2'h0, exp_al}, 1'b0);
         chk("alarm port", {26'h0, exp_al}, {26'h0, alarm});
         m = 6'($urandom);
         apb(1'b1, IDX_STATUS, {2'h0, m}, 1'b0);
         exp_al &= ~m;
         rd(IDX_STATUS, {2'h0, exp_al}, 1'b0);
      end
      $display("alarm test done");
      // Extremes: both pins briefly, then channel one dropped
      do_reset();
      ctrl = 8'h3f;
      apb(1'b1, IDX_CTRL_A, ctrl, 1'b0);
      run(4);
      ctrl = 8'h3d;
      apb(1'b1, IDX_CTRL_A, ctrl, 1'b0);
      run(40);
      rd(IDX_CH0_PEAK, {5'h0, pk[0]}, 1'b0);
      rd(IDX_CH0_FLOOR, {5'h0, fl[0]}, 1'b0);
      rd(IDX_CH1_PEAK, {5'h0, pk[1]}, 1'b0);
      rd(IDX_CH1_FLOOR, {5'h0, fl[1]}, 1'b0);
      $display("tracking test done");
      end_of_test();
   end
endmodule
